// File: hdl/sbm_mapper.sv
// Added by the designer: the APB slave port and the register offsets.
`timescale 1ns/100ps

// How it works
// - in shared mode, bank register low three bits give bits 18..16 of core zone 0 addresses
// - host accesses take memory address from host bus, bank register ignored
// - shared memory up to 512 KB, controller block at most 56 KB
// - firmware sets addr15_enable and wide_ext_memory, then shadow_off
// - firmware loads bank register, then zone 0 width, write type, waits, holds
// - 8-bit host accesses are translated to 8 or 16 bit memory width
// - above 256 KB, port E alternates enabled; host bit 18 selects bank
// - during setup steps core uses external memory, host gets no access
// - host_share_enable is set only after all other shared setup
// - core space is 256 KB; low 128 KB holds code and data
// - byte registers take byte accesses only
// - reserved bits written zero, read back value may be rewritten
// - base memory accesses use zone 1 wait and hold settings
// - base memory at 10000h, first 56 KB mirrored low while shadow on
// - with shadow off 08000h-0DFFFh is external only if addr15_enable
// - external memory off while shadow on; pins and width per settings
// - shared mode with addr15_enable puts bank bits on A17/A16; A18 by alt
// - I/O expansion window FB00h-FBFFh, FB00h-FB11h recreate ports
// - module_config mirror at FBFEh written after each module_config write
// - FB30h-FB5Fh reserved for development board
// - I/O expansion uses io_zone_select, A0-7, read and low_byte_write
// - host access only while host_share_enable and shadow_off are both set
// - shadow_off clear keeps external memory off; set removes low mirror
module sbm_mapper
(
	input wire logic pclk,
	input wire logic presetn,
	input wire logic ce,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [7:0] paddr,
	input wire logic [31:0] pwdata,
	input wire logic [3:0] pstrb,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	input wire logic shared_bios_strap,
	input wire logic width_strap_pin,
	input wire logic core_valid,
	input wire logic core_write,
	input wire logic core_word,
	input wire logic [17:0] core_addr,
	input wire logic host_req,
	input wire logic [18:0] host_addr,
	output logic [18:0] mem_addr,
	output logic [3:0] addr_pin_alt,
	output logic mem_hi_lane,
	output logic data_wide,
	output logic ext_zone_select,
	output logic base_zone_select,
	output logic io_zone_select,
	output logic mem_read,
	output logic low_byte_write,
	output logic high_byte_write,
	output logic [2:0] bus_wait,
	output logic [1:0] bus_hold,
	output logic early_write,
	output logic host_grant,
	output logic core_ext_blocked,
	output logic devboard_hit,
	output logic reserved_hit
);

	logic [7:0] module_config_q;
	logic [7:0] bank_q;
	logic [7:0] zone0_q;
	logic [7:0] zone1_q;
	logic [7:0] io_cfg_q;
	logic [7:0] pe_alt_q;
	logic strap_done_q;
	logic shared_q;
	logic width_strap_q;
	logic mirror_pending_q;
	sbm_pkg::sbm_init_t init_q;
	logic [31:0] rdata_d;
	logic map_hit_d;
	logic wr_en;
	logic byte_ok;
	logic host_grant_d;
	logic wide_d;
	sbm_pkg::sbm_zone_t zone_d;

	function automatic sbm_pkg::sbm_zone_t sbm_decode(input logic [17:0] a,
		input logic shadow_off, input logic addr15_enable);
		sbm_pkg::sbm_zone_t z;
		z = sbm_pkg::Z_RSVD;
		if (a <= sbm_pkg::ADDR_EXT_TOP)
		begin
			if (!shadow_off)
				z = sbm_pkg::Z_BASE;
			else if (a >= sbm_pkg::ADDR_A15_LO && !addr15_enable)
				z = sbm_pkg::Z_RSVD;
			else
				z = sbm_pkg::Z_EXT;
		end
		else if (a >= sbm_pkg::ADDR_IO_LO && a <= sbm_pkg::ADDR_IO_HI)
			z = sbm_pkg::Z_IO;
		else if (a >= sbm_pkg::ADDR_BASE_LO && a <= sbm_pkg::ADDR_BASE_HI)
			z = sbm_pkg::Z_BASE;
		else if ((a >= sbm_pkg::ADDR_RAM_LO && a <= sbm_pkg::ADDR_RAM_HI)
			|| (a >= sbm_pkg::ADDR_HBI_LO && a <= sbm_pkg::ADDR_HBI_HI)
			|| (a >= sbm_pkg::ADDR_BIU_LO && a <= sbm_pkg::ADDR_BIU_HI)
			|| (a >= sbm_pkg::ADDR_ONCHIP_LO && a <= sbm_pkg::ADDR_ONCHIP_HI))
			z = sbm_pkg::Z_ONCHIP;
		return z;
	endfunction : sbm_decode

	// narrows a byte address to the memory word address
	function automatic logic [18:0] sbm_width_addr(input logic [18:0] a,
		input logic wide);
		return wide ? {1'b0, a[18:1]} : a;
	endfunction : sbm_width_addr

	assign wr_en = psel && penable && pwrite && pready;
	assign byte_ok = (pstrb == 4'h1);
	assign wide_d = module_config_q[sbm_pkg::MC_WIDE_EXT] && zone0_q[sbm_pkg::ZC_WIDTH];
	assign host_grant_d = host_req && shared_q && module_config_q[sbm_pkg::MC_SHADOW_OFF]
		&& module_config_q[sbm_pkg::MC_HOST_SHARE];
	assign zone_d = core_valid ? sbm_decode(core_addr, module_config_q[sbm_pkg::MC_SHADOW_OFF],
		module_config_q[sbm_pkg::MC_ADDR15]) : sbm_pkg::Z_NONE;

	// apb read mux; reserved bits read zero
	always_comb
	begin
		rdata_d = 32'h0;
		map_hit_d = 1'b1;
		if (paddr == sbm_pkg::OFF_MODULE_CONFIG)
			rdata_d[7:0] = module_config_q;
		else if (paddr == sbm_pkg::OFF_BANK_SELECT)
			rdata_d[7:0] = bank_q;
		else if (paddr == sbm_pkg::OFF_ZONE0_CONFIG)
			rdata_d[7:0] = zone0_q;
		else if (paddr == sbm_pkg::OFF_ZONE1_CONFIG)
			rdata_d[7:0] = zone1_q;
		else if (paddr == sbm_pkg::OFF_IO_CONFIG)
			rdata_d[7:0] = io_cfg_q;
		else if (paddr == sbm_pkg::OFF_PORT_E_ALT)
			rdata_d[7:0] = pe_alt_q;
		else if (paddr == sbm_pkg::OFF_STATUS)
			rdata_d[7:0] = {2'h0, init_q, host_grant, mirror_pending_q,
				width_strap_q, shared_q};
		else
			map_hit_d = 1'b0;
	end

	// zero-wait slave: answer one cycle after setup
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			pready <= 1'b0;
			pslverr <= 1'b0;
			prdata <= 32'h0;
		end
		else if (ce)
		begin
			pready <= psel && !penable && !pready;
			pslverr <= psel && !penable && (!map_hit_d
				|| (pwrite && (!byte_ok || paddr == sbm_pkg::OFF_STATUS)));
			prdata <= (psel && !penable && !pwrite) ? rdata_d : 32'h0;
		end
	end

	// strap capture on the first enabled edge after reset
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			strap_done_q <= 1'b0;
			shared_q <= 1'b0;
			width_strap_q <= 1'b0;
		end
		else if (ce && !strap_done_q)
		begin
			strap_done_q <= 1'b1;
			shared_q <= !shared_bios_strap;
			width_strap_q <= width_strap_pin;
		end
	end

	// module_config: shadow_off and host_share_enable stick once set
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			module_config_q <= sbm_pkg::MC_RESET;
		else if (ce)
		begin
			if (!strap_done_q && !shared_bios_strap)
				module_config_q[sbm_pkg::MC_ADDR15] <= 1'b1;
			else if (wr_en && byte_ok && paddr == sbm_pkg::OFF_MODULE_CONFIG)
			begin
				module_config_q[5:2] <= pwdata[5:2];
				module_config_q[sbm_pkg::MC_SHADOW_OFF] <= module_config_q[sbm_pkg::MC_SHADOW_OFF]
					|| pwdata[sbm_pkg::MC_SHADOW_OFF];
				module_config_q[sbm_pkg::MC_HOST_SHARE] <= module_config_q[sbm_pkg::MC_HOST_SHARE]
					|| (pwdata[sbm_pkg::MC_HOST_SHARE]
					&& module_config_q[sbm_pkg::MC_SHADOW_OFF]);
			end
		end
	end

	// bank, zone and port e configuration
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			bank_q <= sbm_pkg::BANK_RESET;
			zone0_q <= sbm_pkg::ZC_RESET;
			zone1_q <= sbm_pkg::ZC_RESET;
			io_cfg_q <= sbm_pkg::ZC_RESET;
			pe_alt_q <= sbm_pkg::PE_RESET;
		end
		else if (ce && wr_en && byte_ok)
		begin
			if (paddr == sbm_pkg::OFF_BANK_SELECT)
				bank_q <= pwdata[7:0] & sbm_pkg::BANK_WMASK;
			else if (paddr == sbm_pkg::OFF_ZONE0_CONFIG)
				zone0_q <= pwdata[7:0] & sbm_pkg::ZC_WMASK;
			else if (paddr == sbm_pkg::OFF_ZONE1_CONFIG)
				zone1_q <= pwdata[7:0] & sbm_pkg::ZC_WMASK;
			else if (paddr == sbm_pkg::OFF_IO_CONFIG)
				io_cfg_q <= pwdata[7:0] & sbm_pkg::ZC_WMASK;
			else if (paddr == sbm_pkg::OFF_PORT_E_ALT)
				pe_alt_q <= pwdata[7:0] & sbm_pkg::PE_WMASK;
		end
	end

	// mirror still owed after a module_config write; the set wins
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			mirror_pending_q <= 1'b0;
		else if (ce)
		begin
			if (wr_en && byte_ok && paddr == sbm_pkg::OFF_MODULE_CONFIG)
				mirror_pending_q <= 1'b1;
			else if (core_valid && core_write && core_addr == sbm_pkg::ADDR_MIRROR)
				mirror_pending_q <= 1'b0;
		end
	end

	// setup progress
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			init_q <= sbm_pkg::I_BOOT;
		else if (ce)
		begin
			case (init_q)
				sbm_pkg::I_BOOT:
					if (module_config_q[sbm_pkg::MC_SHADOW_OFF])
						init_q <= sbm_pkg::I_EXTMEM;
				sbm_pkg::I_EXTMEM:
					if (module_config_q[sbm_pkg::MC_HOST_SHARE])
						init_q <= sbm_pkg::I_SHARED;
				default:
					init_q <= sbm_pkg::I_SHARED;
			endcase
		end
	end

	// memory bus request, registered; host has the memory when granted
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			mem_addr <= 19'h0;
			addr_pin_alt <= 4'h0;
			mem_hi_lane <= 1'b0;
			data_wide <= 1'b0;
			ext_zone_select <= 1'b0;
			base_zone_select <= 1'b0;
			io_zone_select <= 1'b0;
			mem_read <= 1'b0;
			low_byte_write <= 1'b0;
			high_byte_write <= 1'b0;
			bus_wait <= 3'h0;
			bus_hold <= 2'h0;
			early_write <= 1'b0;
			host_grant <= 1'b0;
			core_ext_blocked <= 1'b0;
			devboard_hit <= 1'b0;
			reserved_hit <= 1'b0;
		end
		else if (ce)
		begin
			addr_pin_alt <= {pe_alt_q[1] && shared_q && module_config_q[sbm_pkg::MC_ADDR15],
				{2{shared_q && module_config_q[sbm_pkg::MC_ADDR15]}},
				module_config_q[sbm_pkg::MC_ADDR15]};
			data_wide <= wide_d;
			host_grant <= host_grant_d;
			core_ext_blocked <= host_grant_d && zone_d == sbm_pkg::Z_EXT;
			devboard_hit <= zone_d == sbm_pkg::Z_IO && core_addr >= sbm_pkg::ADDR_DEVB_LO
				&& core_addr <= sbm_pkg::ADDR_DEVB_HI;
			reserved_hit <= zone_d == sbm_pkg::Z_RSVD;
			mem_hi_lane <= 1'b0;
			ext_zone_select <= 1'b0;
			base_zone_select <= 1'b0;
			io_zone_select <= 1'b0;
			mem_read <= 1'b0;
			low_byte_write <= 1'b0;
			high_byte_write <= 1'b0;
			if (host_grant_d)
			begin
				mem_addr <= sbm_width_addr({pe_alt_q[0] && host_addr[18],
					host_addr[17:0]}, wide_d);
				mem_hi_lane <= wide_d && host_addr[0];
				ext_zone_select <= 1'b1;
				mem_read <= 1'b1;
				bus_wait <= zone0_q[3:1];
				bus_hold <= zone0_q[5:4];
				early_write <= zone0_q[sbm_pkg::ZC_EARLY_WR];
			end
			else if (zone_d == sbm_pkg::Z_EXT)
			begin
				mem_addr <= sbm_width_addr({shared_q ? bank_q[2:0] : 3'h0,
					module_config_q[sbm_pkg::MC_ADDR15] && core_addr[15],
					core_addr[14:0]}, wide_d);
				mem_hi_lane <= wide_d && core_addr[0] && !core_word;
				ext_zone_select <= 1'b1;
				mem_read <= !core_write;
				low_byte_write <= core_write && (core_word || !core_addr[0] || !wide_d);
				high_byte_write <= core_write && wide_d && (core_word || core_addr[0]);
				bus_wait <= zone0_q[3:1];
				bus_hold <= zone0_q[5:4];
				early_write <= zone0_q[sbm_pkg::ZC_EARLY_WR];
			end
			else if (zone_d == sbm_pkg::Z_BASE)
			begin
				mem_addr <= {3'h0, core_addr[15:0]};
				base_zone_select <= 1'b1;
				mem_read <= !core_write;
				low_byte_write <= core_write;
				bus_wait <= zone1_q[3:1];
				bus_hold <= zone1_q[5:4];
				early_write <= zone1_q[sbm_pkg::ZC_EARLY_WR];
			end
			else if (zone_d == sbm_pkg::Z_IO)
			begin
				mem_addr <= {11'h0, core_addr[7:0]};
				io_zone_select <= 1'b1;
				mem_read <= !core_write;
				low_byte_write <= core_write;
				bus_wait <= io_cfg_q[3:1];
				bus_hold <= io_cfg_q[5:4];
				early_write <= io_cfg_q[sbm_pkg::ZC_EARLY_WR];
			end
		end
	end

	a_host_gate: assert property (@(posedge pclk) disable iff (!presetn)
		host_grant |-> module_config_q[sbm_pkg::MC_HOST_SHARE] && module_config_q[sbm_pkg::MC_SHADOW_OFF])
		else $error("host granted without share and shadow off");

	a_no_early_host: assert property (@(posedge pclk) disable iff (!presetn)
		ce && host_req && !module_config_q[sbm_pkg::MC_HOST_SHARE] |=> !host_grant)
		else $error("host granted during setup");

	a_share_order: assert property (@(posedge pclk) disable iff (!presetn)
		$rose(module_config_q[sbm_pkg::MC_HOST_SHARE]) |-> $past(module_config_q[sbm_pkg::MC_SHADOW_OFF]))
		else $error("share enabled before shadow off");

	a_ext_closed: assert property (@(posedge pclk) disable iff (!presetn)
		!module_config_q[sbm_pkg::MC_SHADOW_OFF] |-> !ext_zone_select)
		else $error("external memory selected with shadow on");

	a_shadow_base: assert property (@(posedge pclk) disable iff (!presetn)
		ce && core_valid && !module_config_q[sbm_pkg::MC_SHADOW_OFF]
		&& core_addr <= sbm_pkg::ADDR_EXT_TOP
		|=> base_zone_select && mem_addr[15:0] == $past(core_addr[15:0]))
		else $error("low mirror not mapped to base memory");

	a_io_window: assert property (@(posedge pclk) disable iff (!presetn)
		ce && core_valid && !host_grant_d && core_addr >= sbm_pkg::ADDR_IO_LO
		&& core_addr <= sbm_pkg::ADDR_IO_HI
		|=> io_zone_select && !ext_zone_select && mem_addr[7:0] == $past(core_addr[7:0]))
		else $error("io expansion access not on io zone");

	a_bank_bits: assert property (@(posedge pclk) disable iff (!presetn)
		ce && zone_d == sbm_pkg::Z_EXT && !host_grant_d && shared_q && !wide_d
		|=> mem_addr[18:16] == $past(bank_q[2:0]))
		else $error("bank bits not on upper address");

	a_host_addr: assert property (@(posedge pclk) disable iff (!presetn)
		ce && host_grant_d && !wide_d |=> mem_addr[17:0] == $past(host_addr[17:0]))
		else $error("host address not passed to memory");

	a_a15_gate: assert property (@(posedge pclk) disable iff (!presetn)
		ce && core_valid && !host_grant_d && module_config_q[sbm_pkg::MC_SHADOW_OFF]
		&& !module_config_q[sbm_pkg::MC_ADDR15] && core_addr >= sbm_pkg::ADDR_A15_LO
		&& core_addr <= sbm_pkg::ADDR_EXT_TOP |=> reserved_hit && !ext_zone_select)
		else $error("upper external range open without addr15_enable");

	a_unmapped_err: assert property (@(posedge pclk) disable iff (!presetn)
		ce && psel && !penable && !pready && !map_hit_d |=> pready && pslverr)
		else $error("unmapped apb access not flagged");

endmodule : sbm_mapper

// File: hdl/sbm_pkg.sv
package sbm_pkg;

	// register byte addresses on the apb port
	localparam logic [7:0] OFF_MODULE_CONFIG = 8'h00;
	localparam logic [7:0] OFF_BANK_SELECT = 8'h04;
	localparam logic [7:0] OFF_ZONE0_CONFIG = 8'h08;
	localparam logic [7:0] OFF_ZONE1_CONFIG = 8'h0c;
	localparam logic [7:0] OFF_IO_CONFIG = 8'h10;
	localparam logic [7:0] OFF_PORT_E_ALT = 8'h14;
	localparam logic [7:0] OFF_STATUS = 8'h18;

	// module_config fields
	localparam int MC_SHADOW_OFF = 0;
	localparam int MC_HOST_SHARE = 1;
	localparam int MC_WIDE_EXT = 2;
	localparam int MC_ADDR15 = 3;
	localparam int MC_EXP_IO = 4;
	localparam int MC_CLK_OUT = 5;

	// zone configuration fields
	localparam int ZC_WIDTH = 0;
	localparam int ZC_WAIT_LO = 1;
	localparam int ZC_HOLD_LO = 4;
	localparam int ZC_EARLY_WR = 6;

	// write masks and reset values
	localparam logic [7:0] MC_WMASK = 8'h3f;
	localparam logic [7:0] BANK_WMASK = 8'h07;
	localparam logic [7:0] ZC_WMASK = 8'h7f;
	localparam logic [7:0] PE_WMASK = 8'h03;
	localparam logic [7:0] MC_RESET = 8'h00;
	localparam logic [7:0] BANK_RESET = 8'h00;
	localparam logic [7:0] ZC_RESET = 8'h40;
	localparam logic [7:0] PE_RESET = 8'h00;

	// core address map
	localparam logic [17:0] ADDR_EXT_TOP = 18'h0dfff;
	localparam logic [17:0] ADDR_A15_LO = 18'h08000;
	localparam logic [17:0] ADDR_RAM_LO = 18'h0f000;
	localparam logic [17:0] ADDR_RAM_HI = 18'h0f3ff;
	localparam logic [17:0] ADDR_HBI_LO = 18'h0f900;
	localparam logic [17:0] ADDR_HBI_HI = 18'h0f90a;
	localparam logic [17:0] ADDR_BIU_LO = 18'h0f980;
	localparam logic [17:0] ADDR_BIU_HI = 18'h0f98f;
	localparam logic [17:0] ADDR_IO_LO = 18'h0fb00;
	localparam logic [17:0] ADDR_IO_HI = 18'h0fbff;
	localparam logic [17:0] ADDR_GPIO_HI = 18'h0fb11;
	localparam logic [17:0] ADDR_DEVB_LO = 18'h0fb30;
	localparam logic [17:0] ADDR_DEVB_HI = 18'h0fb5f;
	localparam logic [17:0] ADDR_MIRROR = 18'h0fbfe;
	localparam logic [17:0] ADDR_ONCHIP_LO = 18'h0fc00;
	localparam logic [17:0] ADDR_ONCHIP_HI = 18'h0ffff;
	localparam logic [17:0] ADDR_BASE_LO = 18'h10000;
	localparam logic [17:0] ADDR_BASE_HI = 18'h1ffff;

	typedef enum logic [2:0]
	{
		Z_NONE = 3'h0,
		Z_EXT = 3'h1,
		Z_BASE = 3'h2,
		Z_IO = 3'h3,
		Z_ONCHIP = 3'h4,
		Z_RSVD = 3'h5
	} sbm_zone_t;

	// gray path: boot -> external memory on -> host sharing on
	typedef enum logic [1:0]
	{
		I_BOOT = 2'b00,
		I_EXTMEM = 2'b01,
		I_SHARED = 2'b11
	} sbm_init_t;

endpackage : sbm_pkg

// File: tb/sbm_host_model.sv
`timescale 1ns/100ps
module sbm_host_model
(
	input wire logic pclk,
	input wire logic presetn,
	input wire logic go,
	input wire logic strap_level,
	input wire logic [18:0] target,
	output logic shared_bios_strap,
	output logic host_req,
	output logic [18:0] host_addr
);
	// strap level held through reset; low picks shared mode
	assign shared_bios_strap = strap_level;
	// one-cycle host request; released address lines toggle
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			host_req <= 1'b0;
			host_addr <= 19'h00000;
		end
		else if (go)
		begin
			host_req <= 1'b1;
			host_addr <= target;
		end
		else
		begin
			host_req <= 1'b0;
			host_addr <= ~host_addr;
		end
	end
endmodule : sbm_host_model

// File: tb/shared_bios_memory_mapping_tb_top.sv
`timescale 1ns/100ps
module shared_bios_memory_mapping_tb_top;
	logic pclk = 1'b0;
	logic presetn = 1'b0;
	logic psel = 1'b0;
	logic penable = 1'b0;
	logic pwrite = 1'b0;
	logic [7:0] paddr = 8'h00;
	logic [31:0] pwdata = 32'h0;
	logic [3:0] pstrb = 4'h1;
	logic [31:0] prdata;
	logic pready, pslverr, strap, host_req;
	logic core_valid = 1'b0;
	logic core_write = 1'b0;
	logic core_word = 1'b0;
	logic [17:0] core_addr = 18'h0;
	logic host_go = 1'b0;
	logic strap_level = 1'b0;
	logic [18:0] host_target = 19'h0;
	logic [18:0] host_addr, mem_addr;
	logic [3:0] pin_alt;
	logic hi_lane, wide, ext_sel, base_sel, io_sel, rd_strobe, lo_wr, hi_wr;
	logic [2:0] bus_wait;
	logic [1:0] bus_hold;
	logic early_wr, grant, blocked, devb, rsvd, err;
	logic [31:0] rd;
	int error_cnt = 0;
	int compares = 0;

	always #20 pclk = ~pclk;

	sbm_host_model sbm_host_model_i (.pclk(pclk), .presetn(presetn), .go(host_go),
		.strap_level(strap_level), .target(host_target), .shared_bios_strap(strap),
		.host_req(host_req),
		.host_addr(host_addr));

	sbm_mapper sbm_mapper_i (.pclk(pclk), .presetn(presetn), .ce(1'b1), .psel(psel),
		.penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb),
		.prdata(prdata), .pready(pready), .pslverr(pslverr), .shared_bios_strap(strap),
		.width_strap_pin(1'b1), .core_valid(core_valid), .core_write(core_write),
		.core_word(core_word), .core_addr(core_addr), .host_req(host_req),
		.host_addr(host_addr), .mem_addr(mem_addr), .addr_pin_alt(pin_alt),
		.mem_hi_lane(hi_lane), .data_wide(wide), .ext_zone_select(ext_sel),
		.base_zone_select(base_sel), .io_zone_select(io_sel), .mem_read(rd_strobe),
		.low_byte_write(lo_wr), .high_byte_write(hi_wr), .bus_wait(bus_wait),
		.bus_hold(bus_hold), .early_write(early_wr), .host_grant(grant),
		.core_ext_blocked(blocked), .devboard_hit(devb), .reserved_hit(rsvd));

	task automatic print_verdict();
		$display("errors=%0d compares=%0d", error_cnt, compares);
		if (error_cnt == 0 && compares > 0)
			$display("*** PASS ***");
		else
			$display("*** FAIL ***");
		$finish;
	endtask : print_verdict

	task automatic check_val(input logic [31:0] got, input logic [31:0] exp);
		compares++;
		if (got !== exp)
		begin
			error_cnt++;
			$display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask : check_val

	task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d,
		input logic [3:0] s);
		int n;
		@(posedge pclk);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		pstrb <= s;
		@(posedge pclk);
		penable <= 1'b1;
		n = 0;
		do
		begin
			@(posedge pclk);
			n++;
		end
		while (pready !== 1'b1 && n < 20);
		if (pready !== 1'b1)
		begin
			error_cnt++;
			print_verdict();
		end
		else
		begin
			rd = prdata;
			err = pslverr;
			psel <= 1'b0;
			penable <= 1'b0;
		end
	endtask : apb

	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		apb(1'b1, a, d, 4'h1);
	endtask : wr

	task automatic rdchk(input logic [7:0] a, input logic [31:0] exp);
		apb(1'b0, a, 32'h0, 4'h1);
		check_val(rd, exp);
	endtask : rdchk

	// one core request, optionally with a host request in the same cycle
	task automatic core_acc(input logic [17:0] a, input logic w, input logic wd,
		input logic h);
		@(posedge pclk);
		host_go <= h;
		@(posedge pclk);
		host_go <= 1'b0;
		core_valid <= 1'b1;
		core_addr <= a;
		core_write <= w;
		core_word <= wd;
		@(posedge pclk);
		core_valid <= 1'b0;
		#1;
	endtask : core_acc

	initial
	begin
		repeat (20) @(posedge pclk);
		presetn <= 1'b1;
		repeat (2) @(posedge pclk);
		rdchk(sbm_pkg::OFF_MODULE_CONFIG, 32'h08);
		rdchk(sbm_pkg::OFF_BANK_SELECT, 32'h00);
		rdchk(sbm_pkg::OFF_ZONE0_CONFIG, 32'h40);
		rdchk(sbm_pkg::OFF_STATUS, 32'h03);
		apb(1'b0, 8'h1c, 32'h0, 4'h1);
		check_val(32'(err), 32'h1);
		check_val(rd, 32'h0);
		wr(sbm_pkg::OFF_BANK_SELECT, 32'hff);
		rdchk(sbm_pkg::OFF_BANK_SELECT, 32'h07);
		apb(1'b1, sbm_pkg::OFF_BANK_SELECT, 32'h03, 4'h3);
		check_val(32'(err), 32'h1);
		rdchk(sbm_pkg::OFF_BANK_SELECT, 32'h07);
		apb(1'b1, sbm_pkg::OFF_STATUS, 32'h0, 4'h1);
		check_val(32'(err), 32'h1);
		wr(sbm_pkg::OFF_ZONE1_CONFIG, 32'h2a);
		wr(sbm_pkg::OFF_MODULE_CONFIG, 32'h0a);
		rdchk(sbm_pkg::OFF_MODULE_CONFIG, 32'h08);
		host_target <= 19'h5abcd;
		core_acc(18'h00100, 1'b0, 1'b0, 1'b1);
		check_val(32'(base_sel), 32'h1);
		check_val(32'(ext_sel), 32'h0);
		check_val(32'(grant), 32'h0);
		check_val(32'(bus_wait), 32'h5);
		check_val(32'(bus_hold), 32'h2);
		check_val(32'({rd_strobe, early_wr}), 32'h2);
		core_acc(18'h10100, 1'b0, 1'b0, 1'b0);
		check_val(32'(base_sel), 32'h1);
		wr(sbm_pkg::OFF_MODULE_CONFIG, 32'h09);
		rdchk(sbm_pkg::OFF_STATUS, 32'h17);
		core_acc(18'h0fbfe, 1'b1, 1'b0, 1'b0);
		check_val(32'(io_sel), 32'h1);
		rdchk(sbm_pkg::OFF_STATUS, 32'h13);
		core_acc(18'h00100, 1'b0, 1'b0, 1'b1);
		check_val(32'(ext_sel), 32'h1);
		check_val(32'(base_sel), 32'h0);
		check_val(32'(grant), 32'h0);
		check_val(32'(mem_addr), 32'h70100);
		check_val(32'(pin_alt), 32'h7);
		wr(sbm_pkg::OFF_PORT_E_ALT, 32'h03);
		core_acc(18'h08000, 1'b0, 1'b0, 1'b0);
		check_val(32'(ext_sel), 32'h1);
		check_val(32'(pin_alt), 32'hf);
		wr(sbm_pkg::OFF_MODULE_CONFIG, 32'h01);
		core_acc(18'h08000, 1'b0, 1'b0, 1'b0);
		check_val(32'(rsvd), 32'h1);
		check_val(32'(ext_sel), 32'h0);
		wr(sbm_pkg::OFF_MODULE_CONFIG, 32'h0d);
		wr(sbm_pkg::OFF_ZONE0_CONFIG, 32'h41);
		core_acc(18'h00101, 1'b0, 1'b0, 1'b0);
		check_val(32'(wide), 32'h1);
		check_val(32'(hi_lane), 32'h1);
		check_val(32'(mem_addr), 32'h38080);
		core_acc(18'h00100, 1'b1, 1'b1, 1'b0);
		check_val(32'({lo_wr, hi_wr}), 32'h3);
		wr(sbm_pkg::OFF_MODULE_CONFIG, 32'h09);
		wr(sbm_pkg::OFF_ZONE0_CONFIG, 32'h40);
		core_acc(18'h0fb10, 1'b1, 1'b0, 1'b0);
		check_val(32'({io_sel, lo_wr}), 32'h3);
		check_val(32'(mem_addr), 32'h10);
		core_acc(18'h0fb40, 1'b0, 1'b0, 1'b0);
		check_val(32'(devb), 32'h1);
		core_acc(18'h20000, 1'b0, 1'b0, 1'b0);
		check_val(32'(rsvd), 32'h1);
		wr(sbm_pkg::OFF_MODULE_CONFIG, 32'h0b);
		core_acc(18'h00100, 1'b0, 1'b0, 1'b1);
		check_val(32'(grant), 32'h1);
		check_val(32'(mem_addr), 32'h5abcd);
		check_val(32'(blocked), 32'h1);
		check_val(32'({rd_strobe, early_wr}), 32'h3);
		wr(sbm_pkg::OFF_MODULE_CONFIG, 32'h08);
		rdchk(sbm_pkg::OFF_MODULE_CONFIG, 32'h0b);
		// second reset with the strap high: non-shared mode
		@(posedge pclk);
		presetn <= 1'b0;
		strap_level <= 1'b1;
		repeat (3) @(posedge pclk);
		presetn <= 1'b1;
		repeat (2) @(posedge pclk);
		rdchk(sbm_pkg::OFF_MODULE_CONFIG, 32'h00);
		rdchk(sbm_pkg::OFF_STATUS, 32'h02);
		wr(sbm_pkg::OFF_BANK_SELECT, 32'h05);
		wr(sbm_pkg::OFF_MODULE_CONFIG, 32'h0b);
		wr(sbm_pkg::OFF_MODULE_CONFIG, 32'h0b);
		core_acc(18'h08100, 1'b0, 1'b0, 1'b1);
		check_val(32'(mem_addr), 32'h08100);
		check_val(32'(pin_alt), 32'h1);
		check_val(32'(grant), 32'h0);
		print_verdict();
	end
endmodule : shared_bios_memory_mapping_tb_top
